// >>> rps_seq.sv
// Recording packet sequencer: ordering, latency timers, byte output
// Function
// - Setup record packets go out first in each recording.
// - A setup record may span several consecutive setup packets.
// - First dynamic packet after setup is a time packet.
// - Other data only after first time packet, before root index.
// - With events enabled, root index packet ends the recording.
// - Time and data packets cover at most 100 ms of data by RTC.
// - A data-holding packet is generated within 100 ms of first word.
// - No empty or idle packets are forced out.
// - Time and data packets are committed within 1000 ms by RTC.
// - With a time source, time packets come at least once a second.
// - With no time source, one time packet still leads the data.
// - Words leave least significant byte first, low address first.
`timescale 1ns/1ns
`default_nettype none

module rps_seq
    import rps_pkg::*;
#(
    parameter logic [31:0] P_CLOSE_TICKS = 32'(RPS_CLOSE_TICKS),
    parameter logic [31:0] P_COMMIT_TICKS = 32'(RPS_COMMIT_TICKS),
    parameter logic [31:0] P_TREQ_TICKS = 32'(RPS_TREQ_TICKS),
    parameter int P_FIFO_DEPTH = RPS_FIFO_DEPTH
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_rec_start,
    input wire logic i_rec_stop,
    input wire logic i_events_en,
    input wire logic i_time_none,
    input wire rps_word_t i_in,
    input wire logic i_in_valid,
    output logic o_in_ready,
    output logic [RPS_BYTE_W-1:0] o_byte,
    output logic o_byte_valid,
    output logic o_byte_last,
    input wire logic i_byte_ready,
    output logic o_time_req,
    output logic o_close_req,
    output logic o_order_err,
    output logic o_commit_late,
    output logic o_rec_done,
    output logic [RPS_RTC_W-1:0] o_rtc
);
    typedef enum logic [2:0] {PH_IDLE, PH_SETUP, PH_DATA, PH_ROOT, PH_DONE}
        rps_phase_t;
    rps_phase_t phase_r, phase_nxt;
    logic [7:0] div_r, pend_r;
    logic tick, active, legal, drop_w, take, wr, ncg_in, fifo_wready;
    logic drop_r, in_pkt_r, ncg_pkt_r, stop_pend_r, setup_seen_r;
    logic time_seen_r, full_r, eop_r, ncg_out_r;
    logic [31:0] gen_cnt_r, tcnt_r, commit_cnt_r;
    rps_word_t rd_word;
    logic [RPS_ITEM_W-1:0] rd_bits;
    logic rd_valid, rd_ready, byte_take, word_end, sent_ncg, pkt_end;
    logic [RPS_WORD_W-1:0] sh_r;
    logic [1:0] idx_r;

    // ------------------------------------------------------------
    // Relative time counter
    // ------------------------------------------------------------
    assign tick = (div_r == 8'(RPS_RTC_DIV - 1));
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            div_r <= '0;
            o_rtc <= '0;
        end else if (tick) begin
            div_r <= '0;
            o_rtc <= o_rtc + 32'h1;
        end else begin
            div_r <= div_r + 8'h1;
        end
    end

    // ------------------------------------------------------------
    // Ordering check on packet starts
    // ------------------------------------------------------------
    assign active = (phase_r == PH_SETUP) || (phase_r == PH_DATA) ||
                    (phase_r == PH_ROOT);
    always_comb begin
        case (phase_r)
            PH_SETUP: legal = (i_in.kind == RPS_K_SETUP) ||
                              (i_in.kind == RPS_K_TIME);
            PH_DATA: legal = (i_in.kind == RPS_K_TIME) ||
                             (i_in.kind == RPS_K_DATA);
            PH_ROOT: legal = (i_in.kind == RPS_K_ROOT);
            default: legal = 1'b0;
        endcase
    end

    assign drop_w = i_in.sop ? !legal : drop_r;
    assign o_in_ready = active && (drop_w || fifo_wready);
    assign take = i_in_valid && o_in_ready;
    assign wr = take && !drop_w;
    assign ncg_in = (i_in.kind == RPS_K_TIME) || (i_in.kind == RPS_K_DATA);
    assign pkt_end = !in_pkt_r || (take && i_in.eop);
    assign o_order_err = take && i_in.sop && !legal;
    assign o_rec_done = (phase_r == PH_DONE);
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || i_rec_start) begin
            drop_r <= 1'b0;
            in_pkt_r <= 1'b0;
            ncg_pkt_r <= 1'b0;
        end else if (take) begin
            drop_r <= drop_w && !i_in.eop;
            in_pkt_r <= !i_in.eop;
            if (i_in.sop) begin
                ncg_pkt_r <= ncg_in && legal;
            end
        end
    end

    // ------------------------------------------------------------
    // Recording phase
    // ------------------------------------------------------------
    always_comb begin
        phase_nxt = phase_r;
        case (phase_r)
            PH_SETUP: if (wr && i_in.sop && i_in.kind == RPS_K_TIME)
                phase_nxt = PH_DATA;
            PH_DATA: if (stop_pend_r && pkt_end)
                phase_nxt = i_events_en ? PH_ROOT : PH_DONE;
            PH_ROOT: if (wr && i_in.eop)
                phase_nxt = PH_DONE;
            default: phase_nxt = phase_r;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            phase_r <= PH_IDLE;
        end else if (i_rec_start) begin
            phase_r <= PH_SETUP;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || i_rec_start) begin
            stop_pend_r <= 1'b0;
            setup_seen_r <= 1'b0;
            time_seen_r <= 1'b0;
        end else begin
            if (i_rec_stop && phase_r == PH_DATA)
                stop_pend_r <= 1'b1;
            else if (phase_r != PH_DATA)
                stop_pend_r <= 1'b0;
            if (wr && i_in.eop && i_in.kind == RPS_K_SETUP)
                setup_seen_r <= 1'b1;
            if (wr && i_in.kind == RPS_K_TIME)
                time_seen_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Packet generation timer and time packet rate
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || i_rec_start || (wr && i_in.sop)) begin
            gen_cnt_r <= '0;
        end else if (tick && in_pkt_r && ncg_pkt_r) begin
            gen_cnt_r <= gen_cnt_r + 32'h1;
        end
    end

    // Only an open packet that already holds data is asked to close
    assign o_close_req = in_pkt_r && ncg_pkt_r &&
                         (gen_cnt_r >= P_CLOSE_TICKS);
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || i_rec_start ||
            (wr && i_in.sop && i_in.kind == RPS_K_TIME)) begin
            tcnt_r <= '0;
        end else if (tick && tcnt_r != 32'hffffffff) begin
            tcnt_r <= tcnt_r + 32'h1;
        end
    end
    assign o_time_req = ((phase_r == PH_SETUP) && setup_seen_r) ||
                        ((phase_r == PH_DATA) && !stop_pend_r &&
                         !i_time_none &&
                         (tcnt_r >= P_TREQ_TICKS));

    // ------------------------------------------------------------
    // Buffer and byte serialiser
    // ------------------------------------------------------------
    rps_fifo #(
        .W(RPS_ITEM_W),
        .D(P_FIFO_DEPTH)
    ) u_fifo (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_wdata(i_in),
        .i_wvalid(i_in_valid && active && !drop_w),
        .o_wready(fifo_wready),
        .o_rdata(rd_bits),
        .o_rvalid(rd_valid),
        .i_rready(rd_ready)
    );
    assign rd_word = rps_word_t'(rd_bits);
    assign o_byte_valid = full_r;
    assign o_byte = sh_r[RPS_BYTE_W-1:0];
    assign byte_take = full_r && i_byte_ready;
    assign word_end = byte_take && (idx_r == 2'(RPS_BYTES - 1));
    assign o_byte_last = full_r && eop_r && (idx_r == 2'(RPS_BYTES - 1));
    assign rd_ready = !full_r || word_end;
    assign sent_ncg = word_end && eop_r && ncg_out_r;
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            sh_r <= '0;
            idx_r <= '0;
            full_r <= 1'b0;
            eop_r <= 1'b0;
            ncg_out_r <= 1'b0;
        end else if (rd_valid && rd_ready) begin
            sh_r <= rd_word.data;
            idx_r <= '0;
            full_r <= 1'b1;
            eop_r <= rd_word.eop;
            ncg_out_r <= (rd_word.kind == RPS_K_TIME) ||
                         (rd_word.kind == RPS_K_DATA);
        end else if (word_end) begin
            full_r <= 1'b0;
        end else if (byte_take) begin
            sh_r <= sh_r >> RPS_BYTE_W;
            idx_r <= idx_r + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // Stream commit timer
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            pend_r <= '0;
        end else if ((wr && i_in.eop && ncg_pkt_r && !i_in.sop) ||
                     (wr && i_in.eop && i_in.sop && ncg_in)) begin
            pend_r <= sent_ncg ? pend_r : pend_r + 8'h1;
        end else if (sent_ncg) begin
            pend_r <= pend_r - 8'h1;
        end
    end
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || sent_ncg ||
            (pend_r == '0 && !(in_pkt_r && ncg_pkt_r))) begin
            commit_cnt_r <= '0;
        end else if (tick && commit_cnt_r != 32'hffffffff) begin
            commit_cnt_r <= commit_cnt_r + 32'h1;
        end
    end

    assign o_commit_late = tick && (commit_cnt_r == P_COMMIT_TICKS);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_word_load;
        rd_valid && rd_ready;
    endsequence

    a_start_restart: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        i_rec_start |=> phase_r == PH_SETUP && gen_cnt_r == '0 &&
                        !time_seen_r)
        else $error("start did not restart the sequencer");
    a_setup_phase: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        wr && i_in.kind == RPS_K_SETUP |-> phase_r == PH_SETUP)
        else $error("setup packet outside the setup phase");
    a_time_first: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        wr && i_in.kind == RPS_K_DATA |-> time_seen_r)
        else $error("data packet ahead of the first time packet");
    a_root_last: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst || i_rec_start)
        phase_r == PH_ROOT && wr && i_in.eop |=>
            phase_r == PH_DONE && !o_in_ready)
        else $error("stream continued after root index");
    a_close_ask: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        wr && i_in.sop |=> !o_close_req)
        else $error("close request on a freshly opened packet");
    a_time_rate: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        wr && i_in.sop && i_in.kind == RPS_K_TIME |=> !o_time_req)
        else $error("time request left standing after a time packet");
    a_byte_order: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        s_word_load |=> o_byte_valid &&
            o_byte == $past(rd_word.data[RPS_BYTE_W-1:0]))
        else $error("word did not start with its low byte");
    a_rtc_step: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        tick |=> o_rtc == $past(o_rtc) + 32'h1 ##1 !tick [*8])
        else $error("relative time counter stepped wrongly");
    a_commit_flag: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        o_commit_late |=> commit_cnt_r == P_COMMIT_TICKS + 32'h1)
        else $error("commit lateness flag misplaced");

endmodule

`default_nettype wire

// >>> rps_pkg.sv
// Package of constants and types for the recording packet sequencer
package rps_pkg;

    // ------------------------------------------------------------
    // Clocking and relative time counter
    // ------------------------------------------------------------
    localparam int RPS_CLK_HZ = 250_000_000;
    localparam int RPS_RTC_HZ = 10_000_000;
    localparam int RPS_RTC_DIV = RPS_CLK_HZ / RPS_RTC_HZ;
    localparam int RPS_RTC_W = 32;
    localparam int RPS_TICKS_PER_MS = RPS_RTC_HZ / 1000;

    // ------------------------------------------------------------
    // Latency and rate limits, as times and as RTC tick counts
    // ------------------------------------------------------------
    localparam int RPS_GEN_MS = 100;
    localparam int RPS_COMMIT_MS = 1000;
    localparam int RPS_TIME_PERIOD_MS = 1000;
    localparam int RPS_GEN_TICKS = RPS_GEN_MS * RPS_TICKS_PER_MS;
    localparam int RPS_COMMIT_TICKS = RPS_COMMIT_MS * RPS_TICKS_PER_MS;
    localparam int RPS_TIME_TICKS = RPS_TIME_PERIOD_MS * RPS_TICKS_PER_MS;
    // Close request leads the generation limit by this margin
    localparam int RPS_CLOSE_MARGIN_TICKS = 10;
    localparam int RPS_CLOSE_TICKS = RPS_GEN_TICKS - RPS_CLOSE_MARGIN_TICKS;
    // Time packet request leads the rate limit by one generation window
    localparam int RPS_TREQ_TICKS = RPS_TIME_TICKS - RPS_GEN_TICKS;

    // ------------------------------------------------------------
    // Data path
    // ------------------------------------------------------------
    localparam int RPS_WORD_W = 32;
    localparam int RPS_BYTE_W = 8;
    localparam int RPS_BYTES = RPS_WORD_W / RPS_BYTE_W;
    localparam int RPS_FIFO_DEPTH = 32;

    typedef enum logic [1:0] {
        RPS_K_SETUP,
        RPS_K_TIME,
        RPS_K_DATA,
        RPS_K_ROOT
    } rps_kind_t;

    typedef struct packed {
        logic [RPS_WORD_W-1:0] data;
        rps_kind_t kind;
        logic sop;
        logic eop;
    } rps_word_t;

    localparam int RPS_ITEM_W = $bits(rps_word_t);

endpackage

// >>> rps_fifo.sv
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none

module rps_fifo #(
    parameter int W = 36,
    parameter int D = 32
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic [W-1:0] i_wdata,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [W-1:0] o_rdata,
    output logic o_rvalid,
    input wire logic i_rready
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic wr;
    logic rd;

    assign o_wready = (cnt_r != (AW+1)'(D));
    assign o_rvalid = (cnt_r != '0);
    assign wr = i_wvalid & o_wready;
    assign rd = o_rvalid & i_rready;
    assign o_rdata = mem[rp_r];

    always_ff @(posedge i_clk_sys) begin
        if (wr) begin
            mem[wp_r] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (wr) begin
                wp_r <= (wp_r == AW'(D - 1)) ? '0 : wp_r + AW'(1);
            end
            if (rd) begin
                rp_r <= (rp_r == AW'(D - 1)) ? '0 : rp_r + AW'(1);
            end
            if (wr && !rd) begin
                cnt_r <= cnt_r + (AW+1)'(1);
            end else if (rd && !wr) begin
                cnt_r <= cnt_r - (AW+1)'(1);
            end
        end
    end

endmodule

`default_nettype wire

// >>> rps_media_model.sv
// Recording medium model that takes the byte stream with selectable pacing
`timescale 1ns/1ns
`default_nettype none

module rps_media_model
    import rps_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic [1:0] i_mode,
    input wire logic [RPS_BYTE_W-1:0] i_byte,
    input wire logic i_byte_valid,
    input wire logic i_byte_last,
    output logic o_byte_ready
);
    // Mode 0 takes every byte, 1 takes one in four cycles, 2 stalls
    logic [8:0] got_q[$];
    logic [3:0] pace_r;

    initial begin
        o_byte_ready = 1'b0;
        pace_r = 4'h0;
    end

    always @(posedge i_clk_sys) begin
        pace_r <= pace_r + 4'h1;
        o_byte_ready <= (i_mode == 2'h0) ||
            (i_mode == 2'h1 && pace_r[1:0] == 2'h3);
    end

    always @(posedge i_clk_sys) begin
        if (i_byte_valid === 1'b1 && o_byte_ready === 1'b1) begin
            got_q.push_back({i_byte_last, i_byte});
        end
    end
endmodule

`default_nettype wire

// >>> recording_packet_sequencer_bench.sv
// Self-checking bench for the recording packet sequencer
`timescale 1ns/1ns
`default_nettype none

module recording_packet_sequencer_bench;
    import rps_pkg::*;
    localparam logic [31:0] CLOSE_T = 32'h14;
    localparam logic [31:0] TREQ_T = 32'h28;
    localparam logic [31:0] COMMIT_T = 32'h64;
    logic i_clk_sys, i_sys_rst, i_rec_start, i_rec_stop, i_events_en;
    logic i_time_none, i_in_valid, i_byte_ready;
    rps_word_t i_in;
    logic o_in_ready, o_byte_valid, o_byte_last, o_time_req, o_close_req;
    logic o_order_err, o_commit_late, o_rec_done;
    logic [RPS_BYTE_W-1:0] o_byte;
    logic [RPS_RTC_W-1:0] o_rtc;
    logic [1:0] mode;
    logic [31:0] rng_state = 32'h77b8e83f;
    logic [8:0] exp_q[$];
    int error_cnt = 0;
    int samples_checked = 0;
    int order_errs = 0;
    int late_cnt = 0;
    int cycles = 0;

    rps_seq #(.P_CLOSE_TICKS(CLOSE_T), .P_COMMIT_TICKS(COMMIT_T),
        .P_TREQ_TICKS(TREQ_T), .P_FIFO_DEPTH(32)) dut (
        .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
        .i_rec_start(i_rec_start), .i_rec_stop(i_rec_stop),
        .i_events_en(i_events_en), .i_time_none(i_time_none),
        .i_in(i_in), .i_in_valid(i_in_valid), .o_in_ready(o_in_ready),
        .o_byte(o_byte), .o_byte_valid(o_byte_valid),
        .o_byte_last(o_byte_last), .i_byte_ready(i_byte_ready),
        .o_time_req(o_time_req), .o_close_req(o_close_req),
        .o_order_err(o_order_err), .o_commit_late(o_commit_late),
        .o_rec_done(o_rec_done), .o_rtc(o_rtc));

    rps_media_model media (
        .i_clk_sys(i_clk_sys), .i_mode(mode), .i_byte(o_byte),
        .i_byte_valid(o_byte_valid), .i_byte_last(o_byte_last),
        .o_byte_ready(i_byte_ready));

    initial i_clk_sys = 1'b0;
    always #2 i_clk_sys = ~i_clk_sys;

    // ----------------------------------------------------------------
    // Pulse counters and hang guard
    // ----------------------------------------------------------------
    always @(posedge i_clk_sys) begin
        if (o_order_err === 1'b1) order_errs++;
        if (o_commit_late === 1'b1) late_cnt++;
        cycles++;
        if (cycles == 40000) begin
            error_cnt++;
            print_verdict();
        end
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        rng_state = rng_state ^ (rng_state << 13);
        rng_state = rng_state ^ (rng_state >> 17);
        rng_state = rng_state ^ (rng_state << 5);
        return rng_state;
    endfunction

    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Leaves valid high on the negedge after the word was taken
    task automatic send_word(input rps_kind_t kind, input logic sop,
                             input logic eop, input logic keep);
        logic [31:0] d;
        d = rnd();
        i_in = '{d, kind, sop, eop};
        i_in_valid = 1'b1;
        while (o_in_ready !== 1'b1) @(negedge i_clk_sys);
        @(negedge i_clk_sys);
        if (keep) begin
            for (int i = 0; i < 4; i++) begin
                exp_q.push_back({eop && i == 3, d[8*i +: 8]});
            end
        end
    endtask

    task automatic send_pkt(input rps_kind_t kind, input int n,
                            input logic keep);
        for (int w = 0; w < n; w++) begin
            send_word(kind, w == 0, w == n - 1, keep);
        end
        i_in_valid = 1'b0;
        @(negedge i_clk_sys);
    endtask

    task automatic wait_ticks(input logic [31:0] n);
        logic [31:0] t0;
        t0 = o_rtc;
        while (o_rtc - t0 < n) @(negedge i_clk_sys);
    endtask

    task automatic pulse(input int which);
        if (which == 0) i_rec_start = 1'b1;
        else i_rec_stop = 1'b1;
        @(negedge i_clk_sys);
        i_rec_start = 1'b0;
        i_rec_stop = 1'b0;
        @(negedge i_clk_sys);
    endtask

    task automatic check_stream();
        int k;
        k = 0;
        while (media.got_q.size() < exp_q.size() && k < 5000) begin
            @(negedge i_clk_sys);
            k++;
        end
        check("stream length", 32'(exp_q.size()), 32'(media.got_q.size()));
        while (exp_q.size() > 0 && media.got_q.size() > 0) begin
            check("stream byte", 32'(exp_q.pop_front()),
                  32'(media.got_q.pop_front()));
        end
        exp_q.delete();
        media.got_q.delete();
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] t;
        int n;
        i_sys_rst = 1'b1;
        {i_rec_start, i_rec_stop, i_in_valid} = 3'h0;
        i_events_en = 1'b1;
        i_time_none = 1'b0;
        i_in = '0;
        mode = 2'h0;
        repeat (10) @(negedge i_clk_sys);
        i_sys_rst = 1'b0;
        check("ready after reset", 32'h0, 32'(o_in_ready));
        check("valid after reset", 32'h0, 32'(o_byte_valid));
        check("rtc after reset", 32'h0, o_rtc);
        t = o_rtc;
        repeat (250) @(negedge i_clk_sys);
        check("rtc rate", 32'ha, o_rtc - t);
        pulse(0);
        send_pkt(RPS_K_DATA, 2, 1'b0);
        check("data before setup", 32'h1, 32'(order_errs));
        send_pkt(RPS_K_SETUP, 3, 1'b1);
        send_pkt(RPS_K_SETUP, 1, 1'b1);
        check("time request", 32'h1, 32'(o_time_req));
        send_pkt(RPS_K_TIME, 1, 1'b1);
        send_pkt(RPS_K_ROOT, 1, 1'b0);
        check("root too early", 32'h2, 32'(order_errs));
        send_pkt(RPS_K_SETUP, 1, 1'b0);
        check("late setup", 32'h3, 32'(order_errs));
        for (int i = 0; i < 8; i++) begin
            mode = 2'(i % 2);
            send_pkt((rnd() & 32'h1) != 0 ? RPS_K_DATA : RPS_K_TIME,
                     1 + int'(rnd() % 4), 1'b1);
        end
        mode = 2'h0;
        check_stream();
        i_time_none = 1'b1;
        send_word(RPS_K_DATA, 1'b1, 1'b0, 1'b1);
        i_in_valid = 1'b0;
        wait_ticks(CLOSE_T - 32'h2);
        check("close early", 32'h0, 32'(o_close_req));
        wait_ticks(32'h3);
        check("close due", 32'h1, 32'(o_close_req));
        send_word(RPS_K_DATA, 1'b0, 1'b1, 1'b1);
        i_in_valid = 1'b0;
        @(negedge i_clk_sys);
        check("close cleared", 32'h0, 32'(o_close_req));
        check_stream();
        i_time_none = 1'b0;
        send_pkt(RPS_K_TIME, 1, 1'b1);
        wait_ticks(TREQ_T - 32'h2);
        check("time req early", 32'h0, 32'(o_time_req));
        wait_ticks(32'h3);
        check("time req due", 32'h1, 32'(o_time_req));
        send_pkt(RPS_K_TIME, 1, 1'b1);
        check("time req served", 32'h0, 32'(o_time_req));
        i_time_none = 1'b1;
        wait_ticks(COMMIT_T + 32'h3);
        check("no time source", 32'h0, 32'(o_time_req));
        check_stream();
        check("no late commit", 32'h0, 32'(late_cnt));
        mode = 2'h2;
        n = 0;
        while (o_in_ready === 1'b1 && n < 60) begin
            send_word(RPS_K_DATA, n == 0, 1'b0, 1'b1);
            n++;
        end
        i_in_valid = 1'b0;
        check("fill count", 32'h1, 32'(n >= 32 && n <= 34));
        wait_ticks(COMMIT_T + 32'h3);
        check("commit late", 32'h1, 32'(late_cnt > 0));
        mode = 2'h0;
        send_word(RPS_K_DATA, 1'b0, 1'b1, 1'b1);
        i_in_valid = 1'b0;
        check_stream();
        pulse(1);
        send_pkt(RPS_K_DATA, 1, 1'b0);
        check("data after stop", 32'h4, 32'(order_errs));
        send_pkt(RPS_K_ROOT, 2, 1'b1);
        check_stream();
        check("done after root", 32'h1, 32'(o_rec_done));
        check("closed input", 32'h0, 32'(o_in_ready));
        i_events_en = 1'b0;
        pulse(0);
        check("restart done", 32'h0, 32'(o_rec_done));
        send_pkt(RPS_K_DATA, 1, 1'b0);
        check("restart order", 32'h5, 32'(order_errs));
        send_pkt(RPS_K_SETUP, 1, 1'b1);
        send_pkt(RPS_K_TIME, 1, 1'b1);
        send_pkt(RPS_K_DATA, 2, 1'b1);
        pulse(1);
        repeat (4) @(negedge i_clk_sys);
        check("done without root", 32'h1, 32'(o_rec_done));
        check_stream();
        print_verdict();
    end
endmodule

`default_nettype wire
